// ---- logic/acvog_top.sv ----
// Operation
// R1 - Valves off until an initiation is seen
// R2 - Jumper chooses relay gating for valve c
// R3 - Bypass lets valve c run without initiation
// R4 - Valve c mirrors its control input level
// R5 - Present DC valve 3 state for linking
// R6 - Integrator may feed control from programmable output
// R7 - Maintained retraction: output follows input level
// R8 - Momentary retraction: toggle per input pulse
// R9 - Beat operation overrides retraction setting
// R10 - Initiation starts sequence, energises safety relay
// R11 - Emergency stop kills outputs; needs fresh initiation (prog_output_a_o keeps following retraction)
// R12 - Retraction off holds output inactive
// R13 - Register control inputs before use
module acvog_top (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Operator switches (pins)
    input wire logic initiate_switch_a_i,
    input wire logic initiate_switch_b_i,
    input wire logic emergency_stop_closed_i,
    // Sequencer valve requests and sequence end
    input wire logic valve_a_req_i,
    input wire logic valve_b_req_i,
    input wire logic dc_valve_c_req_i,
    input wire logic sequence_done_i,
    // Valve c control and jumper (pins)
    input wire logic valve_c_control_in_i,
    input wire logic relay_path_bypass_i,
    // Retraction
    input wire logic [1:0] retract_mode_i,
    input wire logic beat_style_operation_i,
    input wire logic prog_input_e_i,
    // Outputs
    output logic valve_safety_relay_o,
    output logic ac_valve_out_a_o,
    output logic ac_valve_out_b_o,
    output logic ac_valve_out_c_o,
    output logic timer_valve_c_state_out_o,
    output logic prog_output_a_o,
    output logic sequence_active_o
);

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    acvog_sync_if sync_bus ();

    // Order must match the lane numbers; lanes 0 and 7 are spare
    assign sync_bus.raw = {
        1'h0,
        relay_path_bypass_i,
        prog_input_e_i,
        valve_c_control_in_i,
        emergency_stop_closed_i,
        initiate_switch_b_i,
        initiate_switch_a_i,
        1'h0
    };

    acvog_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pins(sync_bus.sync)
    );

    logic init_a;
    logic init_b;
    logic estop_ok;
    logic ctrl_c;
    logic retract_in;
    logic bypass;
    assign init_a = sync_bus.clean[acvog_pkg::LANE_INIT_A];
    assign init_b = sync_bus.clean[acvog_pkg::LANE_INIT_B];
    assign estop_ok = sync_bus.clean[acvog_pkg::LANE_ESTOP];
    assign ctrl_c = sync_bus.clean[acvog_pkg::LANE_CTRL_C]; // [R13]
    assign retract_in = sync_bus.clean[acvog_pkg::LANE_RETRACT]; // [R13]
    assign bypass = sync_bus.clean[acvog_pkg::LANE_BYPASS]; // [R2]

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Both edge detectors use it, so the polarity is written once
    function automatic logic acvog_rise(input logic now_level, input logic last_level);
        return now_level & ~last_level;
    endfunction

    // ------------------------------------------------------------
    // Sequence and safety relay
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACVOG_IDLE = 2'b01,
        ACVOG_RUN = 2'b10
    } acvog_state_e;

    acvog_state_e state;
    acvog_state_e next_state;
    logic init_prev;
    logic init_now;
    logic init_rise;

    // Either pedal starts a weld; both share one relay
    assign init_now = init_a | init_b;
    assign init_rise = acvog_rise(init_now, init_prev);

    // A held switch through an e-stop release must not restart: edge only
    always_comb begin
        next_state = state;
        unique case (state)
            ACVOG_IDLE: begin
                if (estop_ok && init_rise) begin
                    next_state = ACVOG_RUN; // [R10]
                end
            end
            // A pedal still down holds the sequence past its end
            ACVOG_RUN: begin
                if (!estop_ok) begin
                    next_state = ACVOG_IDLE; // [R11]
                end else if (sequence_done_i && !init_now) begin
                    next_state = ACVOG_IDLE;
                end
            end
            default: next_state = ACVOG_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ACVOG_IDLE;
            // Seen as pressed, but the synchroniser resets low, so a pedal held through reset still gives a rising edge
            init_prev <= acvog_pkg::RST_INIT_PREV;
        end else begin
            state <= next_state;
            init_prev <= init_now;
        end
    end

    // ------------------------------------------------------------
    // Retraction
    // ------------------------------------------------------------
    logic retract_prev;
    logic retract_out;
    logic next_retract_out;

    always_comb begin
        next_retract_out = retract_out;
        // Beat mode owns the valve, so the retraction setting is ignored
        if (beat_style_operation_i) begin
            next_retract_out = acvog_pkg::RST_RETRACT; // [R9]
        end else begin
            unique case (retract_mode_i)
                acvog_pkg::RETRACT_MAINTAINED: next_retract_out = retract_in; // [R7]
                acvog_pkg::RETRACT_MOMENTARY: begin
                    if (acvog_rise(retract_in, retract_prev)) begin
                        next_retract_out = ~retract_out; // [R8]
                    end
                end
                // Off, and the reserved code, park the output
                default: next_retract_out = acvog_pkg::RST_RETRACT; // [R12]
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            retract_prev <= acvog_pkg::RST_RETRACT_PREV;
            retract_out <= acvog_pkg::RST_RETRACT;
        end else begin
            retract_prev <= retract_in;
            retract_out <= next_retract_out;
        end
    end

    // ------------------------------------------------------------
    // Valve outputs
    // ------------------------------------------------------------
    logic relay_on;
    logic next_relay;
    logic next_a;
    logic next_b;
    logic next_c;
    logic next_dc_c;
    logic next_seq_active;

    always_comb begin
        relay_on = (state == ACVOG_RUN) && estop_ok;
        next_relay = relay_on; // [R10]
        next_a = relay_on & valve_a_req_i; // [R1] [R11]
        next_b = relay_on & valve_b_req_i; // [R1] [R11]
        next_dc_c = relay_on & dc_valve_c_req_i; // [R5]
        next_seq_active = (next_state == ACVOG_RUN);
        // Bypass has no initiation interlock: a hazard the installer owns
        // E-stop still gates valve c, so the bypass path stops as well
        next_c = ctrl_c & estop_ok & (bypass | relay_on); // [R2] [R3] [R4] [R6]
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Every pin leaves a flop, so no decode glitch reaches a valve
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valve_safety_relay_o <= acvog_pkg::RST_RELAY;
            ac_valve_out_a_o <= acvog_pkg::RST_VALVE;
            ac_valve_out_b_o <= acvog_pkg::RST_VALVE;
            ac_valve_out_c_o <= acvog_pkg::RST_VALVE;
            timer_valve_c_state_out_o <= acvog_pkg::RST_VALVE;
            prog_output_a_o <= acvog_pkg::RST_RETRACT;
            sequence_active_o <= acvog_pkg::RST_SEQ_ACTIVE;
        end else begin
            valve_safety_relay_o <= next_relay;
            ac_valve_out_a_o <= next_a;
            ac_valve_out_b_o <= next_b;
            ac_valve_out_c_o <= next_c;
            timer_valve_c_state_out_o <= next_dc_c;
            prog_output_a_o <= retract_out;
            sequence_active_o <= next_seq_active;
        end
    end

endmodule

// ---- logic/acvog_pkg.sv ----
package acvog_pkg;

    // Retraction setting codes
    localparam logic [1:0] RETRACT_OFF = 2'h0;
    localparam logic [1:0] RETRACT_MAINTAINED = 2'h1;
    localparam logic [1:0] RETRACT_MOMENTARY = 2'h2;

    // Values after reset
    localparam logic RST_RELAY = 1'h0;
    localparam logic RST_VALVE = 1'h0;
    localparam logic RST_RETRACT = 1'h0;
    localparam logic RST_INIT_PREV = 1'h1;
    localparam logic RST_RETRACT_PREV = 1'h0;
    localparam logic RST_SEQ_ACTIVE = 1'h0;
    localparam logic [7:0] RST_SYNC = 8'h00;

    // Lane of each pin in the synchroniser word
    localparam int LANE_INIT_A = 1;
    localparam int LANE_INIT_B = 2;
    localparam int LANE_ESTOP = 3;
    localparam int LANE_CTRL_C = 4;
    localparam int LANE_RETRACT = 5;
    localparam int LANE_BYPASS = 6;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

endpackage

// ---- logic/acvog_sync_if.sv ----
interface acvog_sync_if;
    logic [7:0] raw;
    logic [7:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ---- logic/acvog_sync.sv ----
module acvog_sync (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Pin group
    acvog_sync_if.sync pins
);

    logic [7:0] stage1;
    logic [7:0] stage2;
    logic [7:0] stage3;
    logic [7:0] held;
    logic [7:0] next_held;

    // A change counts only once the second and third stages agree
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_held[i] = (stage2[i] == stage3[i]) ? stage3[i] : held[i];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= acvog_pkg::RST_SYNC;
            stage2 <= acvog_pkg::RST_SYNC;
            stage3 <= acvog_pkg::RST_SYNC;
            held <= acvog_pkg::RST_SYNC;
        end else begin
            stage1 <= pins.raw;
            stage2 <= stage1;
            stage3 <= stage2;
            held <= next_held;
        end
    end

    assign pins.clean = held;

endmodule

// ---- sim/acvog_checker.sv ----
module acvog_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic emergency_stop_closed_i,
    input wire logic relay_path_bypass_i,
    input wire logic valve_c_control_in_i,
    input wire logic [1:0] retract_mode_i,
    input wire logic beat_style_operation_i,
    input wire logic prog_input_e_i,
    input wire logic valve_safety_relay_o,
    input wire logic ac_valve_out_a_o,
    input wire logic ac_valve_out_b_o,
    input wire logic ac_valve_out_c_o,
    input wire logic prog_output_a_o,
    input wire logic sequence_active_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    AST_R1:
        assert property (ac_valve_out_a_o || ac_valve_out_b_o
            |-> valve_safety_relay_o || $past(valve_safety_relay_o)) else $error("valve no relay");
    AST_R11:
        assert property ((!emergency_stop_closed_i)[*6] |-> !(valve_safety_relay_o
            || ac_valve_out_a_o || ac_valve_out_b_o || ac_valve_out_c_o)) else $error("estop");
    AST_R2:
        assert property ((!relay_path_bypass_i && !valve_safety_relay_o)[*6]
            |-> !ac_valve_out_c_o) else $error("valve c ungated");
    AST_R3:
        assert property ((relay_path_bypass_i && valve_c_control_in_i
            && emergency_stop_closed_i)[*7] |-> ac_valve_out_c_o) else $error("bypass");
    AST_R4:
        assert property ((!valve_c_control_in_i)[*7] |-> !ac_valve_out_c_o) else $error("mirror");
    AST_R7:
        assert property ((retract_mode_i == acvog_pkg::RETRACT_MAINTAINED
            && !beat_style_operation_i && $stable(prog_input_e_i))[*8]
            |-> prog_output_a_o == prog_input_e_i) else $error("maintained");
    AST_R12:
        assert property ((retract_mode_i == acvog_pkg::RETRACT_OFF)[*4] |-> !prog_output_a_o)
            else $error("retract off");
    AST_R9:
        assert property (beat_style_operation_i[*4] |-> !prog_output_a_o) else $error("beat");
    AST_R10:
        assert property ($rose(valve_safety_relay_o) |-> $past(sequence_active_o))
            else $error("relay");
    AST_R13:
        assert property ($rose(valve_c_control_in_i) |=> !$rose(ac_valve_out_c_o))
            else $error("unsynced");
    cover property ($rose(valve_safety_relay_o));
    cover property (relay_path_bypass_i && $rose(ac_valve_out_c_o));
    cover property ($rose(prog_output_a_o));
    cover property ($fell(sequence_active_o));
endmodule

// ---- sim/acvog_partner.sv ----
module acvog_partner (
    input wire logic timer_state_i,
    input wire logic retract_out_i,
    input wire logic use_prog_i,
    output logic control_o
);
    // Link on valve c control: timer state, or a programmable output when valve 3 is unused
    assign control_o = use_prog_i ? retract_out_i : timer_state_i;
endmodule

// ---- sim/tb_ac_valve_output_gating.sv ----
module tb_ac_valve_output_gating;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i, rst_i, initiate_switch_a_i, initiate_switch_b_i, emergency_stop_closed_i;
    logic valve_a_req_i, valve_b_req_i, dc_valve_c_req_i, sequence_done_i, valve_c_control_in_i;
    logic relay_path_bypass_i, beat_style_operation_i, prog_input_e_i, use_prog;
    logic [1:0] retract_mode_i;
    logic valve_safety_relay_o, ac_valve_out_a_o, ac_valve_out_b_o, ac_valve_out_c_o;
    logic timer_valve_c_state_out_o, prog_output_a_o, sequence_active_o;
    logic [2:0] r;
    int errors, checks, cyc, k;
    acvog_top u_dut (.*);
    acvog_partner u_link (.timer_state_i(timer_valve_c_state_out_o),
        .retract_out_i(prog_output_a_o), .use_prog_i(use_prog), .control_o(valve_c_control_in_i));
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard, run needs well under 400 cycles
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 1000) begin
            errors++;
            wrap_up;
        end
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        {initiate_switch_a_i, initiate_switch_b_i, valve_a_req_i, valve_b_req_i} = 4'h0;
        {dc_valve_c_req_i, sequence_done_i, relay_path_bypass_i} = 3'h0;
        {beat_style_operation_i, prog_input_e_i, use_prog} = 3'h0;
        emergency_stop_closed_i = 1'b1;
        retract_mode_i = acvog_pkg::RETRACT_OFF;
        rst_i = 1'b1;
        void'($urandom(32'h3C871AB9));
        wt(10);
        rst_i <= 1'b0;
        retract_mode_i <= acvog_pkg::RETRACT_MOMENTARY;
        k = $urandom_range(5, 1);
        repeat (k) begin
            prog_input_e_i <= 1'b1;
            wt(6);
            prog_input_e_i <= 1'b0;
            wt(6);
        end
        chk(prog_output_a_o, k[0]);
        $display("momentary done");
        retract_mode_i <= acvog_pkg::RETRACT_MAINTAINED;
        {relay_path_bypass_i, use_prog, prog_input_e_i} <= 3'h7;
        wt(14);
        chk(prog_output_a_o, 1'b1);
        chk(ac_valve_out_c_o, 1'b1);
        beat_style_operation_i <= 1'b1;
        wt(14);
        chk(prog_output_a_o, 1'b0);
        chk(ac_valve_out_c_o, 1'b0);
        beat_style_operation_i <= 1'b0;
        wt(14);
        chk(prog_output_a_o, 1'b1);
        retract_mode_i <= acvog_pkg::RETRACT_OFF;
        wt(14);
        chk(prog_output_a_o, 1'b0);
        $display("retraction done");
        // Valve c control held high from the retraction output, jumper protected
        {relay_path_bypass_i, use_prog} <= 2'h1;
        retract_mode_i <= acvog_pkg::RETRACT_MAINTAINED;
        {valve_a_req_i, valve_b_req_i, dc_valve_c_req_i} <= 3'h7;
        wt(14);
        chk(valve_safety_relay_o, 1'b0);
        chk(ac_valve_out_a_o, 1'b0);
        chk(ac_valve_out_c_o, 1'b0);
        r = 3'($urandom);
        {valve_a_req_i, valve_b_req_i} <= r[1:0];
        initiate_switch_a_i <= r[2];
        initiate_switch_b_i <= !r[2];
        use_prog <= 1'b0;
        wt(14);
        chk(valve_safety_relay_o, 1'b1);
        chk(ac_valve_out_a_o, r[1]);
        chk(ac_valve_out_b_o, r[0]);
        chk(timer_valve_c_state_out_o, 1'b1);
        chk(ac_valve_out_c_o, 1'b1);
        emergency_stop_closed_i <= 1'b0;
        wt(10);
        chk(valve_safety_relay_o, 1'b0);
        chk(ac_valve_out_c_o, 1'b0);
        chk(ac_valve_out_b_o, 1'b0);
        emergency_stop_closed_i <= 1'b1;
        wt(14);
        chk(valve_safety_relay_o, 1'b0);
        {initiate_switch_a_i, initiate_switch_b_i} <= 2'h0;
        wt(6);
        initiate_switch_b_i <= 1'b1;
        wt(14);
        chk(sequence_active_o, 1'b1);
        chk(valve_safety_relay_o, 1'b1);
        initiate_switch_b_i <= 1'b0;
        sequence_done_i <= 1'b1;
        wt(14);
        chk(sequence_active_o, 1'b0);
        chk(valve_safety_relay_o, 1'b0);
        sequence_done_i <= 1'b0;
        $display("gating done");
        wrap_up;
    end
endmodule
bind acvog_top acvog_checker u_chk (.*);
